// file: core/clock_path_select_sync_update.sv
// Clock path selection, power-down, sync and update control
//
// What this block does
// - Decode prescaler code; 101-111 hold output static
// - Input-section power-down stops buffer, prescaler, tree
// - Oscillator-interface power-down bit
// - Combined power-down stops oscillator and external input
// - Source select: 0 external, 1 oscillator
// - Bypass skips prescaler; never with oscillator
// - Sync power-down stops sync circuitry
// - Distribution reference power-down bit
// - Soft sync bit is inverted sync pin
// - Soft sync high holds obeying channels static
// - Soft sync falling edge fires sync event
// - Update write copies buffered into active
// - Update bit clears itself
// - Direct-route pairs follow source and bypass code
// - No-sync dividers ignore chip-level sync
//
// Design decision made here: the strobed register port.
`include "clk_path_defs.svh"

module clock_path_select_sync_update #(
    parameter int NUM_PAIRS = 3
) (
    // Clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_n_in,
    // Register port
    input  wire logic [9:0]           addr_in,
    input  wire logic [7:0]           wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [7:0]           rdata_out,
    // Sync pin and channel no-sync bits
    input  wire logic                 sync_n_pin_in,
    input  wire logic [NUM_PAIRS-1:0] nosync_in,
    // Prescaler control
    output logic      [2:0]           divide_ratio_out,
    output logic                      prescaler_static_out,
    output logic                      prescaler_bypass_out,
    output logic                      source_osc_out,
    // Power-down controls
    output logic                      pd_ext_buffer_out,
    output logic                      pd_prescaler_out,
    output logic                      pd_clock_tree_out,
    output logic                      pd_osc_interface_out,
    output logic                      pd_oscillator_out,
    output logic                      pd_ext_input_out,
    output logic                      pd_sync_out,
    output logic                      pd_dist_ref_out,
    // Channel sync and routing
    output logic      [NUM_PAIRS-1:0] hold_static_out,
    output logic      [NUM_PAIRS-1:0] sync_release_out,
    output logic      [NUM_PAIRS-1:0] direct_osc_out,
    output logic      [NUM_PAIRS-1:0] direct_ext_out
);
    // Register access decode
    logic wr_ratio;
    logic wr_input;
    logic wr_sys;
    logic wr_route;
    logic wr_update;
    logic update;

    always_comb begin
        wr_ratio  = wr_in && (addr_in == `ADDR_PRESCALER_RATIO);
        wr_input  = wr_in && (addr_in == `ADDR_CLOCK_INPUT_CONTROL);
        wr_sys    = wr_in && (addr_in == `ADDR_SYSTEM_POWER_SYNC);
        wr_route  = wr_in && (addr_in == `ADDR_PAIR_ROUTE);
        wr_update = wr_in && (addr_in == `ADDR_UPDATE_STROBE)
                    && wdata_in[`BIT_UPDATE];
    end

    assign update = wr_update;

    logic [7:0] ratio_buf;
    logic [7:0] ratio_act;
    logic [7:0] input_buf;
    logic [7:0] input_act;
    logic [7:0] sys_buf;
    logic [7:0] sys_act;
    logic [7:0] route_buf;
    logic [7:0] route_act;

    shadow_reg #(.WIDTH(8), .RESET(`RST_PRESCALER_RATIO)) u_ratio (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_in        (wr_ratio),
        .wdata_in     ({5'h00, wdata_in[2:0]}),
        .update_in    (update),
        .buffered_out (ratio_buf),
        .active_out   (ratio_act)
    );
    shadow_reg #(.WIDTH(8), .RESET(`RST_CLOCK_INPUT_CONTROL)) u_input (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_in        (wr_input),
        .wdata_in     ({3'h0, wdata_in[4:0]}),
        .update_in    (update),
        .buffered_out (input_buf),
        .active_out   (input_act)
    );
    shadow_reg #(.WIDTH(8), .RESET(`RST_SYSTEM_POWER_SYNC)) u_sys (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_in        (wr_sys),
        .wdata_in     ({5'h00, wdata_in[2:0]}),
        .update_in    (update),
        .buffered_out (sys_buf),
        .active_out   (sys_act)
    );
    shadow_reg #(.WIDTH(8), .RESET(`RST_PAIR_ROUTE)) u_route (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_in        (wr_route),
        .wdata_in     (wdata_in),
        .update_in    (update),
        .buffered_out (route_buf),
        .active_out   (route_act)
    );

    clk_path_pkg::input_ctrl_t in_ctl;
    clk_path_pkg::sys_ctrl_t   sys_ctl;
    clk_path_pkg::route_t      route_code;
    logic                      bad_combo;

    always_comb begin
        in_ctl     = clk_path_pkg::input_ctrl_t'(input_act[4:0]);
        sys_ctl    = clk_path_pkg::sys_ctrl_t'(sys_act[2:0]);
        route_code = clk_path_pkg::route_t'({in_ctl.source_osc,
                                             in_ctl.bypass});
        bad_combo  = in_ctl.source_osc && in_ctl.bypass;
    end

    // Sync pin synchroniser
    logic sync_meta;
    logic sync_pin_q;
    logic soft_sync_q;
    logic sync_low_q;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sync_meta  <= 1'b1;
            sync_pin_q <= 1'b1;
        end else begin
            sync_meta  <= sync_n_pin_in;
            sync_pin_q <= sync_meta;
        end
    end

    // Combined sync level and its falling edge
    logic next_sync_low;
    logic sync_edge;

    always_comb begin
        next_sync_low = (!sync_pin_q || sys_ctl.soft_sync)
                        && !sys_ctl.pd_sync;
        sync_edge     = sync_low_q && !next_sync_low;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            soft_sync_q <= 1'b0;
            sync_low_q  <= 1'b0;
        end else begin
            soft_sync_q <= sys_ctl.soft_sync;
            sync_low_q  <= next_sync_low;
        end
    end

    // Output registers
    logic [2:0]           next_ratio;
    logic                 next_static;
    logic                 next_bypass;
    logic                 next_osc;
    logic [NUM_PAIRS-1:0] next_hold;
    logic [NUM_PAIRS-1:0] next_release;
    logic [NUM_PAIRS-1:0] next_dosc;
    logic [NUM_PAIRS-1:0] next_dext;
    logic [7:0]           next_rdata;

    always_comb begin
        next_ratio  = ratio_act[2:0];
        next_static = (ratio_act[2:0] > 3'(clk_path_pkg::DIV_6));
        next_osc    = in_ctl.source_osc;
        next_bypass = in_ctl.bypass && !in_ctl.source_osc;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
            always_comb begin
                next_hold[g]    = next_sync_low && !nosync_in[g];
                next_release[g] = sync_edge && !nosync_in[g];
                next_dosc[g]    = route_act[g] &&
                    (route_code == clk_path_pkg::ROUTE_OSC);
                next_dext[g]    = route_act[g] &&
                    (route_code == clk_path_pkg::ROUTE_EXT);
            end
        end
    endgenerate

    always_comb begin
        next_rdata = 8'h00;
        if (rd_in) begin
            if (addr_in == `ADDR_PRESCALER_RATIO) begin
                next_rdata = ratio_buf;
            end else if (addr_in == `ADDR_CLOCK_INPUT_CONTROL) begin
                next_rdata = input_buf;
            end else if (addr_in == `ADDR_SYSTEM_POWER_SYNC) begin
                next_rdata = sys_buf;
            end else if (addr_in == `ADDR_PAIR_ROUTE) begin
                next_rdata = route_buf;
            end else if (addr_in == `ADDR_PATH_STATUS) begin
                next_rdata = {4'h0, bad_combo, sync_low_q,
                              prescaler_static_out, soft_sync_q};
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_out            <= 8'h00;
            divide_ratio_out     <= 3'(`RST_PRESCALER_RATIO);
            prescaler_static_out <= 1'b0;
            prescaler_bypass_out <= 1'b0;
            source_osc_out       <= 1'b0;
            pd_ext_buffer_out    <= 1'b0;
            pd_prescaler_out     <= 1'b0;
            pd_clock_tree_out    <= 1'b0;
            pd_osc_interface_out <= 1'b0;
            pd_oscillator_out    <= 1'b0;
            pd_ext_input_out     <= 1'b0;
            pd_sync_out          <= 1'b0;
            pd_dist_ref_out      <= 1'b0;
            hold_static_out      <= '0;
            sync_release_out     <= '0;
            direct_osc_out       <= '0;
            direct_ext_out       <= '0;
        end else begin
            rdata_out            <= next_rdata;
            divide_ratio_out     <= next_ratio;
            prescaler_static_out <= next_static;
            prescaler_bypass_out <= next_bypass;
            source_osc_out       <= next_osc;
            pd_ext_buffer_out    <= in_ctl.pd_input_section;
            pd_prescaler_out     <= in_ctl.pd_input_section;
            pd_clock_tree_out    <= in_ctl.pd_input_section;
            pd_osc_interface_out <= in_ctl.pd_osc_interface;
            pd_oscillator_out    <= in_ctl.pd_osc_and_ext;
            pd_ext_input_out     <= in_ctl.pd_osc_and_ext;
            pd_sync_out          <= sys_ctl.pd_sync;
            pd_dist_ref_out      <= sys_ctl.pd_dist_ref;
            hold_static_out      <= next_hold;
            sync_release_out     <= next_release;
            direct_osc_out       <= next_dosc;
            direct_ext_out       <= next_dext;
        end
    end

    // Assertions
    sequence s_update_write;
        wr_update;
    endsequence

    AST_RATIO_DECODE: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        1'b1 |=> prescaler_static_out == ($past(ratio_act[2:0]) >= 3'h5))
        else $error("prescaler static decode wrong");
    AST_INPUT_PD: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        1'b1 |=> pd_clock_tree_out == $past(input_act[4]))
        else $error("input section power-down wrong");
    AST_OSC_IF_PD: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        1'b1 |=> pd_osc_interface_out == $past(input_act[3]))
        else $error("oscillator interface power-down wrong");
    AST_BOTH_PD: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        pd_oscillator_out == pd_ext_input_out)
        else $error("combined power-down outputs differ");
    AST_NO_OSC_BYPASS: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        !(prescaler_bypass_out && source_osc_out))
        else $error("bypass with oscillator source");
    AST_SYNC_PD: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        pd_sync_out |-> hold_static_out == '0)
        else $error("hold active while sync powered down");
    AST_RELEASE_EDGE: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (|sync_release_out) |-> $past(|hold_static_out) ||
            $past(sync_low_q))
        else $error("release without prior hold");
    AST_UPDATE_COPY: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        s_update_write |=> input_act == $past(input_buf))
        else $error("update did not copy buffer");
    AST_HOLD_ACTIVE: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        !update |=> $stable(input_act))
        else $error("active changed without update");
    AST_NOSYNC: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        1'b1 |=> (hold_static_out & $past(nosync_in)) == '0)
        else $error("no-sync channel held");
endmodule : clock_path_select_sync_update

// file: core/shadow_reg.sv
// Buffered and active copy of one configuration register
module shadow_reg #(
    parameter int          WIDTH = 8,
    parameter logic [7:0]  RESET = 8'h00
) (
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    // Buffered side
    input  wire logic             wr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    input  wire logic             update_in,
    // Outputs
    output logic      [WIDTH-1:0] buffered_out,
    output logic      [WIDTH-1:0] active_out
);
    logic [WIDTH-1:0] next_buffered;
    logic [WIDTH-1:0] next_active;

    always_comb begin
        next_buffered = wr_in ? wdata_in : buffered_out;
        next_active   = update_in ? buffered_out : active_out;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            buffered_out <= RESET[WIDTH-1:0];
            active_out   <= RESET[WIDTH-1:0];
        end else begin
            buffered_out <= next_buffered;
            active_out   <= next_active;
        end
    end
endmodule : shadow_reg

// file: include/clk_path_defs.svh
// Offsets, field positions, reset values and timing counts of the clock path
`ifndef CLK_PATH_DEFS_SVH
`define CLK_PATH_DEFS_SVH

`define ADDR_PRESCALER_RATIO     10'h1e0
`define ADDR_CLOCK_INPUT_CONTROL 10'h1e1
`define ADDR_SYSTEM_POWER_SYNC   10'h230
`define ADDR_UPDATE_STROBE       10'h232
`define ADDR_PATH_STATUS         10'h233
`define ADDR_PAIR_ROUTE          10'h234

`define RST_PRESCALER_RATIO      8'h02
`define RST_CLOCK_INPUT_CONTROL  8'h00
`define RST_SYSTEM_POWER_SYNC    8'h00
`define RST_PAIR_ROUTE           8'h00

`define BIT_PD_INPUT_SECTION     4
`define BIT_PD_OSC_INTERFACE     3
`define BIT_PD_OSC_AND_EXT       2
`define BIT_SOURCE_SELECT        1
`define BIT_BYPASS               0
`define BIT_PD_SYNC              2
`define BIT_PD_DIST_REF          1
`define BIT_SOFT_SYNC            0
`define BIT_UPDATE               0

`define SYNC_PULSE_CYCLES        4'h2

`endif

// file: include/clk_path_pkg.sv
// Types shared by the clock path configuration logic
package clk_path_pkg;

    typedef enum logic [2:0] {
        DIV_2      = 3'b000,
        DIV_3      = 3'b001,
        DIV_4      = 3'b010,
        DIV_5      = 3'b011,
        DIV_6      = 3'b100
    } prescale_code_t;

    typedef enum logic [1:0] {
        ROUTE_EXT  = 2'b00,
        ROUTE_BAD  = 2'b01,
        ROUTE_OSC  = 2'b10,
        ROUTE_NONE = 2'b11
    } route_t;

    typedef struct packed {
        logic       pd_input_section;
        logic       pd_osc_interface;
        logic       pd_osc_and_ext;
        logic       source_osc;
        logic       bypass;
    } input_ctrl_t;

    typedef struct packed {
        logic       pd_sync;
        logic       pd_dist_ref;
        logic       soft_sync;
    } sys_ctrl_t;

endpackage : clk_path_pkg

// file: verif/clock_path_select_sync_update_test.sv
// Self-checking bench for the clock path select, sync and update block
`include "clk_path_defs.svh"

module clock_path_select_sync_update_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk_in, rst_n_in, wr_in, rd_in, sync_n_pin_in;
    logic [9:0] addr_in;
    logic [7:0] wdata_in, rdata_out;
    logic [2:0] nosync_in, divide_ratio_out, hold_static_out;
    logic [2:0] sync_release_out, direct_osc_out, direct_ext_out;
    logic       prescaler_static_out, prescaler_bypass_out, source_osc_out;
    logic       pd_ext_buffer_out, pd_prescaler_out, pd_clock_tree_out;
    logic       pd_osc_interface_out, pd_oscillator_out, pd_ext_input_out;
    logic       pd_sync_out, pd_dist_ref_out;
    int         failures, checks_done;
    logic [7:0] in_codes [6] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h1e};

    clock_path_select_sync_update #(.NUM_PAIRS(3)) u_dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .sync_n_pin_in(sync_n_pin_in),
        .nosync_in(nosync_in), .divide_ratio_out(divide_ratio_out),
        .prescaler_static_out(prescaler_static_out),
        .prescaler_bypass_out(prescaler_bypass_out),
        .source_osc_out(source_osc_out),
        .pd_ext_buffer_out(pd_ext_buffer_out),
        .pd_prescaler_out(pd_prescaler_out),
        .pd_clock_tree_out(pd_clock_tree_out),
        .pd_osc_interface_out(pd_osc_interface_out),
        .pd_oscillator_out(pd_oscillator_out),
        .pd_ext_input_out(pd_ext_input_out), .pd_sync_out(pd_sync_out),
        .pd_dist_ref_out(pd_dist_ref_out),
        .hold_static_out(hold_static_out),
        .sync_release_out(sync_release_out),
        .direct_osc_out(direct_osc_out), .direct_ext_out(direct_ext_out)
    );

    always #5 sys_clk_in = ~sys_clk_in;

    task automatic end_of_test();
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : settle

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        wr_in    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        rd_in   <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask : rd_chk

    // Buffered write, then update strobe, then let outputs land
    task automatic commit(input logic [9:0] a, input logic [7:0] d);
        wr_reg(a, d);
        wr_reg(`ADDR_UPDATE_STROBE, 8'h01);
        settle(4);
    endtask : commit

    task automatic expect_release(input logic [2:0] exp);
        int         hits;
        logic [2:0] seen;
        hits = 0;
        seen = 3'h0;
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk_in);
            #1;
            if (sync_release_out !== 3'h0) begin
                hits++;
                seen = sync_release_out;
            end
        end
        if (hits == 0) begin
            failures++;
            $display("mismatch at %0t: no release pulse", $time);
            end_of_test();
        end else begin
            chk(8'(hits), 8'h01);
            chk(8'(seen), 8'(exp));
        end
    endtask : expect_release

    task automatic test_reset();
        chk(8'(divide_ratio_out), 8'h02);
        chk({source_osc_out, prescaler_bypass_out, pd_sync_out,
             pd_dist_ref_out, 4'h0}, 8'h00);
        rd_chk(`ADDR_PRESCALER_RATIO, `RST_PRESCALER_RATIO);
        rd_chk(`ADDR_CLOCK_INPUT_CONTROL, 8'h00);
        rd_chk(`ADDR_SYSTEM_POWER_SYNC, 8'h00);
        rd_chk(10'h3ff, 8'h00);
    endtask : test_reset

    task automatic test_divide();
        logic [2:0] prev;
        prev = 3'h2;
        for (int c = 0; c < 8; c++) begin
            wr_reg(`ADDR_PRESCALER_RATIO, 8'(c));
            settle(3);
            chk(8'(divide_ratio_out), 8'(prev));
            rd_chk(`ADDR_PRESCALER_RATIO, 8'(c));
            wr_reg(`ADDR_UPDATE_STROBE, 8'h01);
            settle(4);
            chk(8'(divide_ratio_out), 8'(c));
            chk(8'(prescaler_static_out), 8'(c >= 5));
            rd_chk(`ADDR_UPDATE_STROBE, 8'h00);
            prev = 3'(c);
        end
    endtask : test_divide

    task automatic test_inputs();
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            d = in_codes[i];
            commit(`ADDR_CLOCK_INPUT_CONTROL, d);
            chk({pd_ext_buffer_out, pd_prescaler_out, pd_clock_tree_out,
                 pd_osc_interface_out, pd_oscillator_out, pd_ext_input_out,
                 2'b00}, {{3{d[4]}}, d[3], d[2], d[2], 2'b00});
            chk({6'h0, source_osc_out, prescaler_bypass_out},
                {6'h0, d[1], d[0] & ~d[1]});
        end
    endtask : test_inputs

    task automatic test_route();
        logic [7:0] sel [3] = '{8'h02, 8'h00, 8'h01};
        wr_reg(`ADDR_PAIR_ROUTE, 8'h05);
        for (int i = 0; i < 3; i++) begin
            commit(`ADDR_CLOCK_INPUT_CONTROL, sel[i]);
            chk(8'(direct_osc_out), (i == 0) ? 8'h05 : 8'h00);
            chk(8'(direct_ext_out), (i == 1) ? 8'h05 : 8'h00);
        end
    endtask : test_route

    task automatic test_sync();
        @(posedge sys_clk_in);
        nosync_in <= 3'b010;
        commit(`ADDR_SYSTEM_POWER_SYNC, 8'h01);
        settle(3);
        chk(8'(hold_static_out), 8'h05);
        rd_chk(`ADDR_PATH_STATUS, 8'h07);
        wr_reg(`ADDR_SYSTEM_POWER_SYNC, 8'h00);
        wr_reg(`ADDR_UPDATE_STROBE, 8'h01);
        expect_release(3'b101);
        chk(8'(hold_static_out), 8'h00);
        @(posedge sys_clk_in);
        sync_n_pin_in <= 1'b0;
        settle(7);
        chk(8'(hold_static_out), 8'h05);
        @(posedge sys_clk_in);
        sync_n_pin_in <= 1'b1;
        expect_release(3'b101);
        commit(`ADDR_SYSTEM_POWER_SYNC, 8'h04);
        chk(8'(pd_sync_out), 8'h01);
        @(posedge sys_clk_in);
        sync_n_pin_in <= 1'b0;
        settle(7);
        chk(8'(hold_static_out), 8'h00);
        @(posedge sys_clk_in);
        sync_n_pin_in <= 1'b1;
        commit(`ADDR_SYSTEM_POWER_SYNC, 8'h02);
        chk({pd_sync_out, pd_dist_ref_out}, 8'h01);
    endtask : test_sync

    initial begin
        sys_clk_in    = 1'b0;
        rst_n_in      = 1'b0;
        wr_in         = 1'b0;
        rd_in         = 1'b0;
        addr_in       = 10'h000;
        wdata_in      = 8'h00;
        sync_n_pin_in = 1'b1;
        nosync_in     = 3'b000;
        failures      = 0;
        checks_done   = 0;
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        settle(1);
        test_reset();
        test_divide();
        test_inputs();
        test_route();
        test_sync();
        end_of_test();
    end

endmodule : clock_path_select_sync_update_test
